// File: hdl/pbsi_pkg.sv
// ----------------------------------------
// shared constants for the bus slice
// ----------------------------------------
package pbsi_pkg;

	// timing base
	localparam int CLK_PERIOD_NS = 50;
	// strobe delay after clock b falls, and its width
	localparam int EMS_DELAY_NS = 100;
	localparam int EMS_WIDTH_NS = 200;
	// least times round up, never below one cycle
	localparam int EMS_DELAY_CYC_RAW = (EMS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EMS_DELAY_CYC = (EMS_DELAY_CYC_RAW < 1) ? 1 : EMS_DELAY_CYC_RAW;
	localparam int EMS_WIDTH_CYC_RAW = (EMS_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EMS_WIDTH_CYC = (EMS_WIDTH_CYC_RAW < 1) ? 1 : EMS_WIDTH_CYC_RAW;
	localparam int EMS_CNT_W = 4;

	// widths of the three groups
	localparam int GRP_W = 4;
	localparam int SHARED_W = 8;

	// bit positions inside the synchronised pin vector
	localparam int PIN_PHASE_CLOCK_A = 0;
	localparam int PIN_PHASE_CLOCK_B = 1;
	localparam int PIN_ADS = 2;
	localparam int PIN_PEA_N = 3;
	localparam int PIN_PEB_N = 4;
	localparam int PIN_CES = 5;
	localparam int PIN_CEA = 6;
	localparam int PIN_RRM = 7;
	localparam int PIN_SPO = 8;
	localparam int PIN_BUS = 9;
	localparam int PIN_UP = 17;
	localparam int PIN_STAT = 21;
	localparam int PIN_W = 29;

	// reset values
	localparam logic [PIN_W-1:0] SYNC_RST = 29'h0000000;
	localparam logic [GRP_W-1:0] LAT_RST = 4'h0;
	localparam logic [SHARED_W-1:0] BUS_RST = 8'h00;
	localparam logic [EMS_CNT_W-1:0] EMS_CNT_RST = 4'h0;

	// the four processor phase windows
	typedef enum logic [1:0] {
		PBSI_PH1,
		PBSI_PH2,
		PBSI_PH3,
		PBSI_PH4
	} pbsi_phase_type;

endpackage : pbsi_pkg

// File: hdl/pbsi_sync.sv
`timescale 1ns/1ns
// ----------------------------------------
// two-flop synchroniser for pin inputs
// ----------------------------------------
module pbsi_sync #(
	parameter int WIDTH = pbsi_pkg::PIN_W
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} pbsi_sync_state_type;

	pbsi_sync_state_type s_q;
	pbsi_sync_state_type s_d;

	// first stage feeds only the second stage
	always_comb begin
		s_d.meta = async_i;
		s_d.stable = s_q.meta;
	end

	// both stages reset to zero
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_o = s_q.stable;

endmodule : pbsi_sync

// File: hdl/pbsi_bus_slice.sv
`timescale 1ns/1ns
// How it works
// - straps alone pick address or data slice
// - groups a and b, four bidirectional lines each
// - group c outbound only, four plus one
// - one latch per outbound line
// - latch bus at phase, hold static
// - strap one captures phase 4, zero phase 2
// - inbound paths drive bus only in phase
// - selected when chip-select differs from polarity
// - static copy of chip-select address
// - active-low path enables block inbound drive
// - unselected bus drivers float
// - read timing is inverted phase clock a
// - core write timing from phase samples
// - core phase-2 enable from phase-4 samples
// - prom phase-4 enable from phase-2 sample
// - timing outputs inverted against bus
// - memory strobe follows phase clock b
// - power sync holds write timing off
module pbsi_bus_slice (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic phase_clock_a_i,
	input wire logic phase_clock_b_i,
	input wire logic addr_data_select_strap_i,
	input wire logic path_enable_group_a_n_i,
	input wire logic path_enable_group_b_n_i,
	input wire logic chip_select_polarity_strap_i,
	input wire logic chip_select_address_input_i,
	input wire logic memory_type_strap_i,
	input wire logic power_sync_input_i,
	input wire logic [7:0] shared_bus_lines_i,
	output logic [7:0] shared_bus_lines_o,
	output logic [7:0] shared_bus_lines_oe_o,
	input wire logic [3:0] upper_address_lines_i,
	input wire logic [7:0] static_lines_i,
	output logic [7:0] static_lines_o,
	output logic [7:0] static_lines_oe_o,
	output logic [3:0] static_upper_o,
	output logic chip_select_static_copy_o,
	output logic driver_enable_term_o,
	output logic read_timing_output_o,
	output logic write_timing_output_n_o,
	output logic external_memory_strobe_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------

	// all state in one record, loaded with STATE_RST together by reset
	typedef struct packed {
		pbsi_pkg::pbsi_phase_type phase;
		logic [1:0] warm;
		logic phase_clock_b_prev;
		logic [3:0] lat_a;
		logic [3:0] lat_b;
		logic [3:0] lat_up;
		logic lat_cs;
		logic cea_ph2;
		logic cea_ph4;
		logic wio_ph2;
		logic wio_ph4;
		logic de;
		logic [7:0] bus_out;
		logic [7:0] bus_oe;
		logic [7:0] stat_oe;
		logic rt;
		logic wt_n;
		logic [pbsi_pkg::EMS_CNT_W-1:0] ems_cnt;
		logic external_memory_strobe;
	} pbsi_state_type;

	// bus released, latches clear and write idle after reset
	localparam pbsi_state_type STATE_RST = '{
		phase: pbsi_pkg::PBSI_PH1,
		warm: 2'h0,
		phase_clock_b_prev: 1'b0,
		lat_a: pbsi_pkg::LAT_RST,
		lat_b: pbsi_pkg::LAT_RST,
		lat_up: pbsi_pkg::LAT_RST,
		lat_cs: 1'b0,
		cea_ph2: 1'b0,
		cea_ph4: 1'b0,
		wio_ph2: 1'b0,
		wio_ph4: 1'b0,
		de: 1'b0,
		bus_out: pbsi_pkg::BUS_RST,
		bus_oe: pbsi_pkg::BUS_RST,
		stat_oe: pbsi_pkg::BUS_RST,
		rt: 1'b0,
		wt_n: 1'b1,
		ems_cnt: pbsi_pkg::EMS_CNT_RST,
		external_memory_strobe: 1'b0
	};

	// one down-counter covers both the strobe delay and its width
	localparam logic [pbsi_pkg::EMS_CNT_W-1:0] EMS_LOAD =
		pbsi_pkg::EMS_CNT_W'(pbsi_pkg::EMS_DELAY_CYC + pbsi_pkg::EMS_WIDTH_CYC);
	localparam logic [pbsi_pkg::EMS_CNT_W-1:0] EMS_ON =
		pbsi_pkg::EMS_CNT_W'(pbsi_pkg::EMS_WIDTH_CYC);

	pbsi_state_type s_q;
	pbsi_state_type s_d;

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------

	logic [pbsi_pkg::PIN_W-1:0] pins_raw;
	logic [pbsi_pkg::PIN_W-1:0] pins;

	// every pin, straps included, crosses two flops first
	// straps are static, but a wired strap may still bounce at power-up
	always_comb begin
		pins_raw = '0;
		pins_raw[pbsi_pkg::PIN_PHASE_CLOCK_A] = phase_clock_a_i;
		pins_raw[pbsi_pkg::PIN_PHASE_CLOCK_B] = phase_clock_b_i;
		pins_raw[pbsi_pkg::PIN_ADS] = addr_data_select_strap_i;
		pins_raw[pbsi_pkg::PIN_PEA_N] = path_enable_group_a_n_i;
		pins_raw[pbsi_pkg::PIN_PEB_N] = path_enable_group_b_n_i;
		pins_raw[pbsi_pkg::PIN_CES] = chip_select_polarity_strap_i;
		pins_raw[pbsi_pkg::PIN_CEA] = chip_select_address_input_i;
		pins_raw[pbsi_pkg::PIN_RRM] = memory_type_strap_i;
		pins_raw[pbsi_pkg::PIN_SPO] = power_sync_input_i;
		pins_raw[pbsi_pkg::PIN_BUS +: 8] = shared_bus_lines_i;
		pins_raw[pbsi_pkg::PIN_UP +: 4] = upper_address_lines_i;
		pins_raw[pbsi_pkg::PIN_STAT +: 8] = static_lines_i;
	end

	pbsi_sync #(
		.WIDTH(pbsi_pkg::PIN_W)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.async_i(pins_raw),
		.sync_o(pins)
	);

	// named views of the synchronised pins
	// bit order is fixed by the package positions
	logic phase_clock_a;
	logic phase_clock_b;
	logic addr_data_select_strap;
	logic pea_n;
	logic peb_n;
	logic chip_select_polarity_strap;
	logic cea;
	logic wio;
	logic power_sync_input;
	logic [7:0] bus_in;
	logic [3:0] up_in;
	logic [7:0] stat_in;

	assign phase_clock_a = pins[pbsi_pkg::PIN_PHASE_CLOCK_A];
	assign phase_clock_b = pins[pbsi_pkg::PIN_PHASE_CLOCK_B];
	assign addr_data_select_strap = pins[pbsi_pkg::PIN_ADS];
	assign pea_n = pins[pbsi_pkg::PIN_PEA_N];
	assign peb_n = pins[pbsi_pkg::PIN_PEB_N];
	assign chip_select_polarity_strap = pins[pbsi_pkg::PIN_CES];
	assign cea = pins[pbsi_pkg::PIN_CEA];
	// grounded for rom, tied to the write command for core
	assign wio = pins[pbsi_pkg::PIN_RRM];
	assign power_sync_input = pins[pbsi_pkg::PIN_SPO];
	assign bus_in = pins[pbsi_pkg::PIN_BUS +: 8];
	assign up_in = pins[pbsi_pkg::PIN_UP +: 4];
	assign stat_in = pins[pbsi_pkg::PIN_STAT +: 8];

	// ----------------------------------------
	// phase decode and enables
	// ----------------------------------------

	pbsi_pkg::pbsi_phase_type phase_now;
	logic cap_now;
	logic drive_now;
	logic de_ph2;
	logic de_ph4;
	logic de_sel;
	logic wt_now;
	logic [7:0] grp_n;

	// quadrature pair: a low in phases 1-2, b high in 1 and 4
	always_comb begin
		case ({phase_clock_a, phase_clock_b})
			2'b01: phase_now = pbsi_pkg::PBSI_PH1;
			2'b00: phase_now = pbsi_pkg::PBSI_PH2;
			2'b10: phase_now = pbsi_pkg::PBSI_PH3;
			2'b11: phase_now = pbsi_pkg::PBSI_PH4;
			default: phase_now = pbsi_pkg::PBSI_PH1;
		endcase
	end

	// the address/data strap alone picks the capture phase
	assign cap_now = addr_data_select_strap ? (phase_now == pbsi_pkg::PBSI_PH4)
		: (phase_now == pbsi_pkg::PBSI_PH2);
	// inbound drive shares the capture phase slot;
	// a group drives the bus only while its static side is off, so the two uses never clash
	assign drive_now = addr_data_select_strap ? (phase_now == pbsi_pkg::PBSI_PH4)
		: (phase_now == pbsi_pkg::PBSI_PH2);

	// core: phase-4 command and select gate phase-2 drive
	assign de_ph2 = s_q.wio_ph4 & (s_q.cea_ph4 ^ chip_select_polarity_strap);
	// prom: phase-2 select alone gates phase-4 drive
	assign de_ph4 = s_q.cea_ph2 ^ chip_select_polarity_strap;
	// select is active when address differs from the strap
	assign de_sel = addr_data_select_strap ? de_ph4 : de_ph2;

	// write only in phases 3-4, never before power sync
	assign wt_now = s_q.wio_ph2 & (s_q.cea_ph4 ^ chip_select_polarity_strap)
		& power_sync_input
		& ((phase_now == pbsi_pkg::PBSI_PH3) | (phase_now == pbsi_pkg::PBSI_PH4));

	// group path enable per shared bus bit, active low
	// one enable per bit keeps the drive vector a plain mask
	genvar gi;
	generate
		for (gi = 0; gi < pbsi_pkg::SHARED_W; gi++) begin : g_grp
			if (gi < pbsi_pkg::GRP_W) begin : g_a
				assign grp_n[gi] = pea_n;
			end else begin : g_b
				assign grp_n[gi] = peb_n;
			end
		end
	endgenerate

	// ----------------------------------------
	// phase order guard
	// ----------------------------------------

	pbsi_pkg::pbsi_phase_type phase_next;
	logic step_ok;
	logic live;

	// the only phase that may follow the last one seen
	always_comb begin
		case (s_q.phase)
			pbsi_pkg::PBSI_PH1: phase_next = pbsi_pkg::PBSI_PH2;
			pbsi_pkg::PBSI_PH2: phase_next = pbsi_pkg::PBSI_PH3;
			pbsi_pkg::PBSI_PH3: phase_next = pbsi_pkg::PBSI_PH4;
			pbsi_pkg::PBSI_PH4: phase_next = pbsi_pkg::PBSI_PH1;
			default: phase_next = pbsi_pkg::PBSI_PH1;
		endcase
	end

	// a skipped phase means a clock level was lost in the synchroniser;
	// capturing then would latch a value from the wrong window
	assign step_ok = (phase_now == s_q.phase) | (phase_now == phase_next);
	// the synchroniser shows reset zeros for two edges after release,
	// which decode as phase 2 and would cause a false capture
	assign live = s_q.warm[1] & step_ok;

	// ----------------------------------------
	// next state
	// ----------------------------------------

	// one pass fills the whole next state
	always_comb begin
		s_d = s_q;
		s_d.phase = phase_now;
		s_d.phase_clock_b_prev = phase_clock_b;
		// fills with ones as the synchroniser fills with real pin levels
		s_d.warm = {s_q.warm[0], 1'b1};

		// outbound latches follow the bus in the capture phase only
		if (cap_now && live) begin
			s_d.lat_a = bus_in[3:0];
			s_d.lat_b = bus_in[7:4];
			s_d.lat_up = up_in;
			s_d.lat_cs = cea;
		end

		// phase samples for the core and prom equations
		// held a whole cycle, so each equation sees one phase's value
		if (live && (phase_now == pbsi_pkg::PBSI_PH2)) begin
			s_d.cea_ph2 = cea;
			s_d.wio_ph2 = wio;
		end
		if (live && (phase_now == pbsi_pkg::PBSI_PH4)) begin
			s_d.cea_ph4 = cea;
			s_d.wio_ph4 = wio;
		end

		s_d.de = de_sel;

		// inbound drive: selected, in phase, left path disabled
		s_d.bus_out = stat_in;
		s_d.bus_oe = {8{de_sel & drive_now}} & grp_n;
		// anything not enabled above floats on the bus
		if (!de_sel) begin
			s_d.bus_oe = pbsi_pkg::BUS_RST;
		end

		// static side drives only while its left path is enabled
		s_d.stat_oe = ~grp_n;

		// timing outputs are inverted against the bus side
		s_d.rt = ~phase_clock_a;
		s_d.wt_n = ~wt_now;

		// strobe: delay then width, restarted on each b fall
		// b falls once per processor cycle, well after the strobe ends
		if (s_q.phase_clock_b_prev & ~phase_clock_b) begin
			s_d.ems_cnt = EMS_LOAD;
		end else if (s_q.ems_cnt != pbsi_pkg::EMS_CNT_RST) begin
			s_d.ems_cnt = s_q.ems_cnt - 4'h1;
		end
		s_d.external_memory_strobe = (s_q.ems_cnt != pbsi_pkg::EMS_CNT_RST) && (s_q.ems_cnt <= EMS_ON);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------

	// constant reset: bus released, write timing idle high
	// the synchroniser shares this reset, so both release together
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------

	// all outputs come straight from flops
	assign shared_bus_lines_o = s_q.bus_out;
	assign shared_bus_lines_oe_o = s_q.bus_oe;
	assign static_lines_o = {s_q.lat_b, s_q.lat_a};
	assign static_lines_oe_o = s_q.stat_oe;
	// group c has no inbound path, so it always drives
	assign static_upper_o = s_q.lat_up;
	assign chip_select_static_copy_o = s_q.lat_cs;
	// the selected enable term, for board-level gating
	assign driver_enable_term_o = s_q.de;
	assign read_timing_output_o = s_q.rt;
	assign write_timing_output_n_o = s_q.wt_n;
	assign external_memory_strobe_o = s_q.external_memory_strobe;

endmodule : pbsi_bus_slice

// File: tb/pbsi_bus_slice_assertions.sv
`timescale 1ns/1ns
// ----------------------------------------
// port checks for the bus slice
// ----------------------------------------
module pbsi_bus_slice_assertions (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic phase_clock_a_i,
	input wire logic phase_clock_b_i,
	input wire logic addr_data_select_strap_i,
	input wire logic path_enable_group_a_n_i,
	input wire logic path_enable_group_b_n_i,
	input wire logic chip_select_polarity_strap_i,
	input wire logic chip_select_address_input_i,
	input wire logic memory_type_strap_i,
	input wire logic power_sync_input_i,
	input wire logic [7:0] shared_bus_lines_i,
	input wire logic [7:0] shared_bus_lines_o,
	input wire logic [7:0] shared_bus_lines_oe_o,
	input wire logic [3:0] upper_address_lines_i,
	input wire logic [7:0] static_lines_i,
	input wire logic [7:0] static_lines_o,
	input wire logic [7:0] static_lines_oe_o,
	input wire logic [3:0] static_upper_o,
	input wire logic chip_select_static_copy_o,
	input wire logic driver_enable_term_o,
	input wire logic read_timing_output_o,
	input wire logic write_timing_output_n_o,
	input wire logic external_memory_strobe_o
);
	// pin history: outputs lag pins by three edges, so judge only steady stretches
	logic [8:0] pins;
	logic [8:0] q1, q2, q3, q4;
	logic [2:0] age_q;
	logic st, sel;
	assign pins = {memory_type_strap_i, phase_clock_a_i, phase_clock_b_i,
		addr_data_select_strap_i, path_enable_group_a_n_i, path_enable_group_b_n_i,
		chip_select_polarity_strap_i, chip_select_address_input_i, power_sync_input_i};
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			age_q <= 3'h0;
		end else if (age_q != 3'h7) begin
			age_q <= age_q + 3'h1;
		end
	end
	always_ff @(posedge core_clk_i) begin
		{q4, q3, q2, q1} <= {q3, q2, q1, pins};
	end
	assign st = (age_q == 3'h7) && (q2 == q3) && (q3 == q4);
	assign sel = q3[1] ^ q3[2];
	// capture and drive share one phase: 4 with strap high, else 2
	function automatic logic capt(input logic [8:0] q);
		return q[5] ? (q[7:6] == 2'h3) : (q[7:6] == 2'h0);
	endfunction : capt
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	rt_inverse_a: assert property (st |-> read_timing_output_o == !q3[7])
		else $error("read timing not inverse of clock a");
	float_unsel_a: assert property (st && !sel |-> shared_bus_lines_oe_o == 8'h00)
		else $error("bus driven while not selected");
	path_block_a: assert property (st && !q3[4] |-> shared_bus_lines_oe_o[3:0] == 4'h0)
		else $error("group a drives bus while outbound");
	// phase-2 data drive is a core mode feature and needs the write command strap
	drive_gate_a: assert property (st && sel && capt(q3) && q3[4] && q3[3]
		&& (q3[5] || q3[8]) |-> shared_bus_lines_oe_o == 8'hFF)
		else $error("bus not driven in drive phase");
	drive_off_a: assert property (st && !capt(q3) |-> shared_bus_lines_oe_o == 8'h00)
		else $error("bus driven outside drive phase");
	static_oe_a: assert property (st |-> static_lines_oe_o == {{4{!q3[3]}}, {4{!q3[4]}}})
		else $error("static enables wrong");
	write_hold_a: assert property (st && !q3[0] |-> write_timing_output_n_o)
		else $error("write timing before power sync");
	write_phase_a: assert property (st && !write_timing_output_n_o |-> q3[7])
		else $error("write timing outside phases 3 and 4");
	latch_phase_a: assert property (age_q == 3'h7 && $changed(static_upper_o)
		|-> capt(q2) || capt(q3) || capt(q4))
		else $error("latch changed outside capture phase");
	strobe_width_a: assert property ($rose(external_memory_strobe_o)
		|-> external_memory_strobe_o [*4] ##1 !external_memory_strobe_o)
		else $error("strobe width wrong");
	strobe_lead_a: assert property (age_q == 3'h7 && $fell(phase_clock_b_i)
		|-> ##[3:8] $rose(external_memory_strobe_o))
		else $error("strobe missing after clock b fall");
	cover property (shared_bus_lines_oe_o != 8'h00);
	cover property ($rose(external_memory_strobe_o));
	cover property (!write_timing_output_n_o);
endmodule : pbsi_bus_slice_assertions

bind pbsi_bus_slice pbsi_bus_slice_assertions chk (.*);

// File: tb/pbsi_phase_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// processor phase bus and static memory
// ----------------------------------------
module pbsi_phase_model (
	input wire logic core_clk_i,
	input wire logic [7:0] pat_i,
	output logic phase_clock_a_o,
	output logic phase_clock_b_o,
	output logic [7:0] bus_o,
	output logic [3:0] upper_o,
	output logic [7:0] mem_o
);
	// four cycles a phase, phases strictly 1 to 4
	logic [3:0] cnt_q = 4'h0;
	logic [1:0] ph;
	assign ph = cnt_q[3:2];
	always @(negedge core_clk_i) begin
		cnt_q <= cnt_q + 4'h1;
	end
	// a high in phases 3 and 4, b low in phases 2 and 3
	assign phase_clock_a_o = ph[1];
	assign phase_clock_b_o = ph[1] ~^ ph[0];
	// new bus value every phase, so a wrong capture phase shows
	assign bus_o = pat_i ^ {6'h00, ph};
	assign upper_o = pat_i[3:0] ^ {2'h0, ph};
	// memory data unlike anything on the bus
	assign mem_o = ~pat_i;
endmodule : pbsi_phase_model

// File: tb/tb_top.sv
`timescale 1ns/1ns
// ----------------------------------------
// bench for the bus slice
// ----------------------------------------
module tb_top;
	typedef struct packed {
		logic addr_data_select_strap, pea_n, peb_n, chip_select_polarity_strap, cea, memory_type_strap;
		logic [7:0] pat, st;
		logic [3:0] up;
		logic de;
	} pbsi_row_type;
	logic core_clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic phase_clock_a_i, phase_clock_b_i, addr_data_select_strap_i;
	logic path_enable_group_a_n_i, path_enable_group_b_n_i, chip_select_polarity_strap_i;
	logic chip_select_address_input_i, memory_type_strap_i, power_sync_input_i;
	logic [7:0] shared_bus_lines_i, shared_bus_lines_o, shared_bus_lines_oe_o;
	logic [3:0] upper_address_lines_i, static_upper_o;
	logic [7:0] static_lines_i, static_lines_o, static_lines_oe_o;
	logic chip_select_static_copy_o, driver_enable_term_o, read_timing_output_o;
	logic write_timing_output_n_o, external_memory_strobe_o;
	logic [7:0] proc_bus, mem_bus, pat, oe_seen;
	logic wr_low, mon_on;
	int bad_count = 0;
	int checks_done = 0;
	// the four strap modes, then a deselected slice
	pbsi_row_type rows [5] = '{
		'{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'h5A, 8'h5B, 4'hB, 1'h0},
		'{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 8'h3C, 8'h3F, 4'hF, 1'h1},
		'{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 8'hA5, 8'hA6, 4'h6, 1'h1},
		'{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 8'h96, 8'h97, 4'h7, 1'h1},
		'{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 8'h0F, 8'h0E, 4'hE, 1'h0}};
	always #25 core_clk_i = ~core_clk_i;
	// each wire is the driver with its enable up, else the far side
	assign shared_bus_lines_i = (shared_bus_lines_oe_o & shared_bus_lines_o)
		| (~shared_bus_lines_oe_o & proc_bus);
	assign static_lines_i = (static_lines_oe_o & static_lines_o) | (~static_lines_oe_o & mem_bus);
	pbsi_phase_model far (.core_clk_i(core_clk_i), .pat_i(pat), .phase_clock_a_o(phase_clock_a_i),
		.phase_clock_b_o(phase_clock_b_i), .bus_o(proc_bus), .upper_o(upper_address_lines_i),
		.mem_o(mem_bus));
	pbsi_bus_slice dut (.*);
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	// gather bus drive and write pulses; falling edge, so outputs have settled
	always @(negedge core_clk_i) begin
		if (mon_on) begin
			oe_seen <= oe_seen | shared_bus_lines_oe_o;
			wr_low <= wr_low | !write_timing_output_n_o;
			if (|shared_bus_lines_oe_o) begin
				check("bus data", mem_bus & shared_bus_lines_oe_o,
					shared_bus_lines_o & shared_bus_lines_oe_o);
			end
		end
	end
	// two processor cycles to settle, two watched, then compare
	task automatic row_test(input pbsi_row_type r);
		logic sel;
		logic [7:0] mask;
		@(negedge core_clk_i);
		{addr_data_select_strap_i, path_enable_group_a_n_i, path_enable_group_b_n_i,
			chip_select_polarity_strap_i, chip_select_address_input_i,
			memory_type_strap_i} = r[26:21];
		pat = r.pat;
		sel = r.cea ^ r.chip_select_polarity_strap;
		mask = {{4{!r.peb_n}}, {4{!r.pea_n}}};
		repeat (32) @(negedge core_clk_i);
		oe_seen = 8'h00;
		wr_low = 1'h0;
		mon_on = 1'h1;
		repeat (32) @(negedge core_clk_i);
		mon_on = 1'h0;
		check("static lines", r.st & mask, static_lines_o & mask);
		check("static upper", {4'h0, r.up}, {4'h0, static_upper_o});
		check("static enables", mask, static_lines_oe_o);
		check("cs copy", {7'h00, r.cea}, {7'h00, chip_select_static_copy_o});
		check("drive enable", {7'h00, r.de}, {7'h00, driver_enable_term_o});
		check("bus drive", sel ? ~mask : 8'h00, oe_seen);
		check("write time", {7'h00, r.memory_type_strap & sel & power_sync_input_i},
			{7'h00, wr_low});
		$display("row test done");
	endtask : row_test
	initial begin
		{addr_data_select_strap_i, path_enable_group_a_n_i, path_enable_group_b_n_i} = 3'h0;
		{chip_select_polarity_strap_i, chip_select_address_input_i, memory_type_strap_i} = 3'h0;
		power_sync_input_i = 1'h1;
		pat = 8'h00;
		oe_seen = 8'h00;
		wr_low = 1'h0;
		mon_on = 1'h0;
		repeat (6) @(posedge core_clk_i);
		@(negedge core_clk_i);
		rst_i = 1'h0;
		foreach (rows[i]) row_test(rows[i]);
		// core mode write held off until power is synchronised
		power_sync_input_i = 1'h0;
		row_test(rows[2]);
		power_sync_input_i = 1'h1;
		// reset in mid-run: drivers off, write idle, strobe low
		rst_i = 1'h1;
		@(negedge core_clk_i);
		check("reset drive", 8'h00, shared_bus_lines_oe_o | static_lines_oe_o);
		check("reset flags", 8'h01, {5'h00, external_memory_strobe_o, read_timing_output_o,
			write_timing_output_n_o});
		$display("reset test done");
		rst_i = 1'h0;
		row_test(rows[3]);
		wrap_up();
	end
	// hang guard, well past the run length of under a thousand cycles
	initial begin
		#100000;
		bad_count++;
		wrap_up();
	end
endmodule : tb_top
